// file: bench/timebase_clock_tree_tb.sv
// Purpose: Self-checking bench for the chassis timebase clock tree
// Assumes: Trim zero gives exact nominal tick rates for primary and 10 MHz; 13.1072 and 12.8 MHz increments truncate
// Notes:   Inputs change on the falling edge; counts taken by timer_sink
`timescale 1ns/10ps
module timebase_clock_tree_tb;
  logic core_clk, rst, mode_req, ref_locked, prof_wr, prof_port, prof_val, rtc_valid;
  logic [11:0] ctr_src_sel;
  logic [2:0] ai_src_sel, ao_src_sel, carrier_clk, user_carrier_clk, module_master_clk;
  logic [8:0] derived_half;
  logic signed [23:0] osc_trim;
  logic [63:0] rtc_time, sys_time;
  logic [1:0] primary_ticks, port_profile, port_explicit, port_l34_udp, port_delay_rr;
  logic tb20_clk, tb100k_clk, onboard_tick, derived_clk, derived_tick, ai_tb_tick;
  logic ao_tb_tick, user_top_tick, mode_is_user, port_end_station, sys_time_valid, clr;
  logic [3:0] ctr_src_tick;
  logic [15:0] ctr_cnt [4];
  logic [15:0] ai_cnt, ao_cnt, top_cnt, derived_cnt, master_cnt;
  int miscompares = 0;
  int samples_checked = 0;

  timebase_clock_tree #(.NUM_COUNTERS(4), .NUM_PORTS(2), .PORT_W(1)) i_dut (
    .core_clk(core_clk), .rst(rst), .mode_req(mode_req), .ctr_src_sel(ctr_src_sel),
    .ai_src_sel(ai_src_sel), .ao_src_sel(ao_src_sel), .derived_half(derived_half),
    .ref_locked(ref_locked), .osc_trim(osc_trim), .prof_wr(prof_wr), .prof_port(prof_port),
    .prof_val(prof_val), .rtc_valid(rtc_valid), .rtc_time(rtc_time),
    .primary_ticks(primary_ticks), .tb20_clk(tb20_clk), .tb100k_clk(tb100k_clk),
    .onboard_tick(onboard_tick), .derived_clk(derived_clk), .derived_tick(derived_tick),
    .carrier_clk(carrier_clk), .ctr_src_tick(ctr_src_tick), .ai_tb_tick(ai_tb_tick),
    .ao_tb_tick(ao_tb_tick), .user_top_tick(user_top_tick),
    .user_carrier_clk(user_carrier_clk), .module_master_clk(module_master_clk),
    .mode_is_user(mode_is_user), .port_profile(port_profile), .port_explicit(port_explicit),
    .port_l34_udp(port_l34_udp), .port_delay_rr(port_delay_rr),
    .port_end_station(port_end_station), .sys_time(sys_time), .sys_time_valid(sys_time_valid));

  timer_sink #(.NUM_COUNTERS(4)) i_sink (
    .core_clk(core_clk), .clr(clr), .ctr_tick(ctr_src_tick), .ai_tick(ai_tb_tick),
    .ao_tick(ao_tb_tick), .top_tick(user_top_tick), .derived_tick(derived_tick),
    .master_clk(module_master_clk), .ctr_cnt(ctr_cnt), .ai_cnt(ai_cnt), .ao_cnt(ao_cnt),
    .top_cnt(top_cnt), .derived_cnt(derived_cnt), .master_cnt(master_cnt));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic in_range(input string what, input logic [15:0] seen, input int lo, input int hi);
    check(what, 64'(seen >= lo && seen <= hi), 64'h1);
  endtask : in_range

  // Cycles until sig changes, bounded
  task automatic count_hold(ref logic sig, output int n);
    logic prev;
    n = 0;
    prev = sig;
    while (sig === prev) begin
      @(negedge core_clk);
      n++;
      if (n > 600) begin
        miscompares++;
        test_done();
      end
    end
  endtask : count_hold

  task automatic window(input int cycles);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    repeat (cycles) @(negedge core_clk);
  endtask : window

  task automatic test_reset();
    check("port_profile", port_profile, 0);
    check("port_explicit", port_explicit, 0);
    check("end_station", port_end_station, 1);
    check("time_valid", sys_time_valid, 0);
    check("mode_user", mode_is_user, 0);
  endtask : test_reset

  task automatic test_primary();
    logic prev;
    int n;
    repeat (2) @(negedge core_clk);
    repeat (8) begin
      prev = tb20_clk;
      @(negedge core_clk);
      check("primary_ticks", primary_ticks, 2);
      check("onboard_tick", onboard_tick, 1);
      check("tb20_toggle", tb20_clk, !prev);
    end
    count_hold(tb100k_clk, n);
    count_hold(tb100k_clk, n);
    check("tb100k_half", n, 200);
  endtask : test_primary

  task automatic test_sources();
    ctr_src_sel = {3'h6, 3'h5, 3'h1, 3'h0};
    ai_src_sel = 3'h1;
    ao_src_sel = 3'h5;
    repeat (4) @(negedge core_clk);
    window(400);
    check("ctr_80m", ctr_cnt[0], 400);
    check("ctr_20m", ctr_cnt[1], 200);
    check("ctr_10m", ctr_cnt[2], 100);
    check("ctr_off6", ctr_cnt[3], 0);
    check("ai_20m", ai_cnt, 200);
    check("ao_10m", ao_cnt, 100);
    ctr_src_sel = {3'h7, 3'h4, 3'h3, 3'h2};
    ai_src_sel = 3'h2;
    ao_src_sel = 3'h3;
    repeat (4) @(negedge core_clk);
    window(800);
    check("ctr_100k", ctr_cnt[0], 2);
    in_range("ctr_13m", ctr_cnt[1], 262, 263);
    in_range("ctr_12m8", ctr_cnt[2], 255, 257);
    check("ctr_off7", ctr_cnt[3], 0);
    check("ai_100k", ai_cnt, 2);
    in_range("ao_13m", ao_cnt, 262, 263);
  endtask : test_sources

  task automatic test_derived();
    int n;
    derived_half = 9'h003;
    repeat (20) @(negedge core_clk);
    window(60);
    check("derived_run", derived_cnt, 10);
    count_hold(derived_clk, n);
    count_hold(derived_clk, n);
    check("derived_half", n, 3);
    derived_half = 9'h000;
    repeat (20) @(negedge core_clk);
    window(60);
    check("derived_stop", derived_cnt, 0);
  endtask : test_derived

  task automatic test_profile();
    prof_wr = 1'b1;
    prof_port = 1'b0;
    prof_val = 1'b1;
    @(negedge core_clk);
    prof_port = 1'b1;
    prof_val = 1'b0;
    @(negedge core_clk);
    prof_wr = 1'b0;
    repeat (2) @(negedge core_clk);
    check("port_profile", port_profile, 2'b01);
    check("port_explicit", port_explicit, 2'b11);
    check("port_l34_udp", port_l34_udp, 2'b01);
    check("port_delay_rr", port_delay_rr, 2'b01);
    check("end_station", port_end_station, 1);
  endtask : test_profile

  task automatic test_rtc();
    int n;
    rtc_time = 64'h0123_4567_89ab_cdef;
    rtc_valid = 1'b1;
    count_hold(sys_time_valid, n);
    check("sys_time_load", sys_time, 64'h0123_4567_89ab_cdef);
    rtc_time = 64'h0000_0000_0000_0000;
    repeat (10) @(negedge core_clk);
    check("sys_time_run", sys_time, 64'h0123_4567_89ab_cdef + 250);
  endtask : test_rtc

  task automatic test_user();
    int n;
    logic [2:0] prev;
    mode_req = 1'b1;
    count_hold(mode_is_user, n);
    check("mode_edge", tb100k_clk, 1);
    repeat (3) @(negedge core_clk);
    window(400);
    check("ctr_user", ctr_cnt[0], 0);
    check("ai_user", ai_cnt, 0);
    check("top_user", top_cnt, 400);
    in_range("master_10m", master_cnt, 99, 101);
    repeat (4) begin
      prev = carrier_clk;
      @(negedge core_clk);
      check("user_carrier", user_carrier_clk, prev);
    end
    mode_req = 1'b0;
    count_hold(mode_is_user, n);
    repeat (3) @(negedge core_clk);
    window(400);
    check("top_driver", top_cnt, 0);
    check("ai_driver", ai_cnt, 1);
    check("user_carrier_off", user_carrier_clk, 0);
  endtask : test_user

  task automatic test_trim();
    int sum;
    ref_locked = 1'b1;
    osc_trim = 24'sh10_0000;
    repeat (8) @(negedge core_clk);
    sum = 0;
    repeat (4096) begin
      @(negedge core_clk);
      sum += int'(primary_ticks);
    end
    in_range("trim_ticks", 16'(sum), 8193, 8194);
  endtask : test_trim

  initial begin
    rst = 1'b1;
    mode_req = 1'b0;
    ctr_src_sel = 12'h000;
    ai_src_sel = 3'h6;
    ao_src_sel = 3'h6;
    derived_half = 9'h000;
    ref_locked = 1'b0;
    osc_trim = 24'sh00_0000;
    prof_wr = 1'b0;
    prof_port = 1'b0;
    prof_val = 1'b0;
    rtc_valid = 1'b0;
    rtc_time = 64'h0000_0000_0000_0000;
    clr = 1'b1;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    test_reset();
    test_primary();
    test_sources();
    test_derived();
    test_profile();
    test_rtc();
    test_user();
    test_trim();
    test_done();
  end
endmodule : timebase_clock_tree_tb

// file: bench/timer_sink.sv
// Purpose: Far-side model of counter/timers, timing logic and modules
// Assumes: Tick inputs are one core cycle wide; clr restarts every count
// Notes:   Module master count follows rising edges of the 10 MHz carrier
`timescale 1ns/10ps
module timer_sink #(
  parameter int NUM_COUNTERS = 4
) (
  input  wire logic                    core_clk,
  input  wire logic                    clr,
  input  wire logic [NUM_COUNTERS-1:0] ctr_tick,
  input  wire logic                    ai_tick,
  input  wire logic                    ao_tick,
  input  wire logic                    top_tick,
  input  wire logic                    derived_tick,
  input  wire logic [2:0]              master_clk,
  output logic      [15:0]             ctr_cnt [NUM_COUNTERS],
  output logic      [15:0]             ai_cnt,
  output logic      [15:0]             ao_cnt,
  output logic      [15:0]             top_cnt,
  output logic      [15:0]             derived_cnt,
  output logic      [15:0]             master_cnt
);
  logic master_reg;

  // Edge history of the module master clock
  always_ff @(posedge core_clk) begin
    master_reg <= master_clk[2];
  end

  // Pulse counters of the downstream consumers
  always_ff @(posedge core_clk) begin
    if (clr) begin
      for (int i = 0; i < NUM_COUNTERS; i++) ctr_cnt[i] <= 16'h0000;
      ai_cnt      <= 16'h0000;
      ao_cnt      <= 16'h0000;
      top_cnt     <= 16'h0000;
      derived_cnt <= 16'h0000;
      master_cnt  <= 16'h0000;
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) ctr_cnt[i] <= ctr_cnt[i] + 16'(ctr_tick[i]);
      ai_cnt      <= ai_cnt + 16'(ai_tick);
      ao_cnt      <= ao_cnt + 16'(ao_tick);
      top_cnt     <= top_cnt + 16'(top_tick);
      derived_cnt <= derived_cnt + 16'(derived_tick);
      master_cnt  <= master_cnt + 16'(master_clk[2] & ~master_reg);
    end
  end
endmodule : timer_sink

// file: hw/div_toggle.sv
// Purpose: Synchronous divider counting incoming ticks, toggling at half period
// Assumes: Half count not below the largest tick burst; zero holds the output
// Notes:   Tick out pulses for one cycle on each rising edge of level
`timescale 1ns/10ps
module div_toggle #(
  parameter int CNT_W  = 9,
  parameter int TICK_W = 2
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [TICK_W-1:0] tick_in,
  input  wire logic [CNT_W-1:0]  half_cnt,
  output logic                   level,
  output logic                   tick_out
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W:0]   sum;

  generate
    if (CNT_W <= TICK_W) begin : g_bad
      $error("div_toggle: counter narrower than tick burst");
    end
  endgenerate

  assign sum = {1'b0, cnt_reg} + (CNT_W+1)'(tick_in);

  // Count ticks, toggle on half period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      level    <= 1'b0;
      tick_out <= 1'b0;
    end else if (half_cnt == '0) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else if (sum >= {1'b0, half_cnt}) begin
      cnt_reg  <= CNT_W'(sum - {1'b0, half_cnt});
      level    <= ~level;
      tick_out <= ~level;
    end else begin
      cnt_reg  <= sum[CNT_W-1:0];
      tick_out <= 1'b0;
    end
  end

endmodule : div_toggle

// file: hw/nco_tick.sv
// Purpose: Phase accumulator standing for one oscillator-derived frequency
// Assumes: Increment is a fraction of 2**FRAC_W per core cycle
// Notes:   Ticks count whole periods crossed this cycle; level is phase MSB
`timescale 1ns/10ps
module nco_tick #(
  parameter int FRAC_W = 32,
  parameter int TICK_W = 2
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic [FRAC_W+TICK_W-1:0] inc,
  output logic      [TICK_W-1:0]        ticks,
  output logic                          level
);

  logic [FRAC_W-1:0]        acc_reg;
  logic [FRAC_W+TICK_W-1:0] sum;

  generate
    if (FRAC_W < 8 || TICK_W < 1) begin : g_bad
      $error("nco_tick: widths too small");
    end
  endgenerate

  assign sum = {{TICK_W{1'b0}}, acc_reg} + inc;

  // Accumulate phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_reg <= '0;
      ticks   <= '0;
      level   <= 1'b0;
    end else begin
      acc_reg <= sum[FRAC_W-1:0];
      ticks   <= sum[FRAC_W+TICK_W-1:FRAC_W];
      level   <= sum[FRAC_W-1];
    end
  end

endmodule : nco_tick

// file: hw/timebase_clock_tree.sv
// Purpose: Chassis clock tree: primary, divided, onboard, derived and carrier
//          timebases, source selection, port time profiles, startup time load
// Assumes: Timebases carried as tick streams in the 40 MHz core domain
// Notes:
// Notes on behaviour
// R1: Primary 80 MHz timebase from onboard oscillator
// R2: 20 MHz, 100 kHz divided from primary
// R3: Driver mode: 80 MHz selectable counter source; SRC_TB80 gives one pulse per core cycle (40 MHz)
// R4: Driver mode: 20M/100k for AI/AO, counters
// R5: Onboard 40 MHz phase aligned to 80 MHz
// R6: User mode: onboard clock is top clock
// R7: Derived clocks generated from onboard clock
// R8: Carrier timebases direct from clock generator
// R9: Driver mode: carriers for AI/AO, counters
// R10: User mode: carriers to logic, module masters
// R11: All timebases disciplined to oscillator reference
// R12: Separate time profile per network port
// R13: Unchosen port defaults to generalized profile
// R14: 2008 profile: UDP over IP, delay request-response
// R15: Always end station, never bridge
// R16: Startup loads system time from real-time clock
// R17: Mode selects sources; switching glitch-free
// R18: Synchronous dividers by 4, 800, 50 percent
`timescale 1ns/10ps
module timebase_clock_tree #(
  parameter int NUM_COUNTERS = 4,
  parameter int NUM_PORTS    = 2,
  parameter int PORT_W       = 1
) (
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  input  wire logic                                mode_req,
  input  wire logic [3*NUM_COUNTERS-1:0]           ctr_src_sel,
  input  wire logic [2:0]                          ai_src_sel,
  input  wire logic [2:0]                          ao_src_sel,
  input  wire logic [timebase_pkg::DIV_W-1:0]      derived_half,
  input  wire logic                                ref_locked,
  input  wire logic signed [timebase_pkg::TRIM_W-1:0] osc_trim,
  input  wire logic                                prof_wr,
  input  wire logic [PORT_W-1:0]                   prof_port,
  input  wire logic                                prof_val,
  input  wire logic                                rtc_valid,
  input  wire logic [63:0]                         rtc_time,
  output logic [timebase_pkg::TICK_W-1:0]          primary_ticks,
  output logic                                     tb20_clk,
  output logic                                     tb100k_clk,
  output logic                                     onboard_tick,
  output logic                                     derived_clk,
  output logic                                     derived_tick,
  output logic [timebase_pkg::NUM_CARRIERS-1:0]    carrier_clk,
  output logic [NUM_COUNTERS-1:0]                  ctr_src_tick,
  output logic                                     ai_tb_tick,
  output logic                                     ao_tb_tick,
  output logic                                     user_top_tick,
  output logic [timebase_pkg::NUM_CARRIERS-1:0]    user_carrier_clk,
  output logic [timebase_pkg::NUM_CARRIERS-1:0]    module_master_clk,
  output logic                                     mode_is_user,
  output logic [NUM_PORTS-1:0]                     port_profile,
  output logic [NUM_PORTS-1:0]                     port_explicit,
  output logic [NUM_PORTS-1:0]                     port_l34_udp,
  output logic [NUM_PORTS-1:0]                     port_delay_rr,
  output logic                                     port_end_station,
  output logic [63:0]                              sys_time,
  output logic                                     sys_time_valid
);

  localparam int NC = timebase_pkg::NUM_CARRIERS;

  generate
    if (NUM_COUNTERS < 1 || NUM_PORTS < 1 || NUM_PORTS > (1 << PORT_W)) begin : g_bad
      $error("timebase_clock_tree: bad counter or port parameters");
    end
  endgenerate

  // Source decode shared by counters and AI/AO timing
  function automatic logic src_pick(input logic [2:0] sel, input logic [5:0] ticks_vec);
    logic pick;
    pick = 1'b0;
    case (sel)
      timebase_pkg::SRC_TB80:   pick = ticks_vec[0];
      timebase_pkg::SRC_TB20:   pick = ticks_vec[1];
      timebase_pkg::SRC_TB100K: pick = ticks_vec[2];
      timebase_pkg::SRC_C13:    pick = ticks_vec[3];
      timebase_pkg::SRC_C12P8:  pick = ticks_vec[4];
      timebase_pkg::SRC_C10:    pick = ticks_vec[5];
      default:                  pick = 1'b0;
    endcase
    return pick;
  endfunction : src_pick

  // Oscillator discipline trim
  logic signed [timebase_pkg::INC_W-1:0] trim_ext;
  logic        [timebase_pkg::INC_W-1:0] primary_inc;
  logic        [timebase_pkg::INC_W-1:0] carrier_inc [NC];

  assign trim_ext    = ref_locked ? timebase_pkg::INC_W'(osc_trim) : '0; // R11
  assign primary_inc = timebase_pkg::PRIMARY_INC + trim_ext; // R11

  nco_tick #(
    .FRAC_W (timebase_pkg::FRAC_W),
    .TICK_W (timebase_pkg::TICK_W)
  ) u_primary (
    .core_clk (core_clk),
    .rst      (rst),
    .inc      (primary_inc),
    .ticks    (primary_ticks), // R1
    .level    ()
  );

  // Dividers by 4 and by 800 on primary ticks
  logic tb20_tick;
  logic tb100k_tick;

  div_toggle #(
    .CNT_W  (timebase_pkg::DIV_W),
    .TICK_W (timebase_pkg::TICK_W)
  ) u_div20 (
    .core_clk (core_clk),
    .rst      (rst),
    .tick_in  (primary_ticks),
    .half_cnt (timebase_pkg::DIV20_HALF), // R2 R18
    .level    (tb20_clk),
    .tick_out (tb20_tick)
  );

  div_toggle #(
    .CNT_W  (timebase_pkg::DIV_W),
    .TICK_W (timebase_pkg::TICK_W)
  ) u_div100k (
    .core_clk (core_clk),
    .rst      (rst),
    .tick_in  (primary_ticks),
    .half_cnt (timebase_pkg::DIV100K_HALF), // R2 R18
    .level    (tb100k_clk),
    .tick_out (tb100k_tick)
  );

  // Onboard clock: one tick in each cycle that completes a pair of primary ticks
  logic       prim_par_reg;
  logic [2:0] prim_sum;

  assign prim_sum = {2'b00, prim_par_reg} + {1'b0, primary_ticks};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prim_par_reg <= 1'b0;
      onboard_tick <= 1'b0;
    end else begin
      prim_par_reg <= prim_sum[0]; // R5
      onboard_tick <= prim_sum >= 3'(timebase_pkg::PRIMARY_PER_ONBOARD); // R5
    end
  end

  div_toggle #(
    .CNT_W  (timebase_pkg::DIV_W),
    .TICK_W (1)
  ) u_derived (
    .core_clk (core_clk),
    .rst      (rst),
    .tick_in  (onboard_tick), // R7
    .half_cnt (derived_half),
    .level    (derived_clk),
    .tick_out (derived_tick)
  );

  // Carrier clocks from the clock generator
  logic [timebase_pkg::TICK_W-1:0] carrier_ticks [NC];
  logic [NC-1:0]                   carrier_tick;

  genvar gc;
  generate
    for (gc = 0; gc < NC; gc++) begin : g_carrier
      assign carrier_inc[gc] = timebase_pkg::CARRIER_INC[gc] + trim_ext; // R8 R11
      nco_tick #(
        .FRAC_W (timebase_pkg::FRAC_W),
        .TICK_W (timebase_pkg::TICK_W)
      ) u_carrier (
        .core_clk (core_clk),
        .rst      (rst),
        .inc      (carrier_inc[gc]),
        .ticks    (carrier_ticks[gc]),
        .level    (carrier_clk[gc])
      );
      assign carrier_tick[gc] = |carrier_ticks[gc];
    end
  endgenerate

  // Mode changes only at a 100 kHz period edge
  timebase_pkg::mode_type mode_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= timebase_pkg::MODE_DRIVER;
    end else if (tb100k_tick) begin
      mode_reg <= mode_req ? timebase_pkg::MODE_USER : timebase_pkg::MODE_DRIVER; // R17
    end
  end

  assign mode_is_user = (mode_reg == timebase_pkg::MODE_USER);

  logic [5:0] src_vec;
  assign src_vec = {carrier_tick, tb100k_tick, tb20_tick, |primary_ticks};

  // Driver-mode source selection
  genvar gk;
  generate
    for (gk = 0; gk < NUM_COUNTERS; gk++) begin : g_ctr
      always_ff @(posedge core_clk) begin
        if (rst) begin
          ctr_src_tick[gk] <= 1'b0;
        end else begin
          ctr_src_tick[gk] <= !mode_is_user && src_pick(ctr_src_sel[3*gk +: 3], src_vec); // R3 R4 R9 R17
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ai_tb_tick <= 1'b0;
      ao_tb_tick <= 1'b0;
    end else begin
      ai_tb_tick <= !mode_is_user && src_pick(ai_src_sel, src_vec); // R4 R9
      ao_tb_tick <= !mode_is_user && src_pick(ao_src_sel, src_vec); // R4 R9
    end
  end

  // User-mode clocks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      user_top_tick     <= 1'b0;
      user_carrier_clk  <= '0;
      module_master_clk <= '0;
    end else begin
      user_top_tick     <= mode_is_user && onboard_tick; // R6 R17
      user_carrier_clk  <= mode_is_user ? carrier_clk : '0; // R10
      module_master_clk <= mode_is_user ? carrier_clk : '0; // R10
    end
  end

  // Per-port time profile
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge core_clk) begin
        if (rst) begin
          port_profile[gp]  <= timebase_pkg::PROF_GPTP; // R13
          port_explicit[gp] <= 1'b0;
        end else if (prof_wr && prof_port == PORT_W'(gp)) begin
          port_profile[gp]  <= prof_val; // R12
          port_explicit[gp] <= 1'b1;
        end
      end
      assign port_l34_udp[gp]  = (port_profile[gp] == timebase_pkg::PROF_PTP08); // R14
      assign port_delay_rr[gp] = (port_profile[gp] == timebase_pkg::PROF_PTP08); // R14
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_end_station <= 1'b1;
    end else begin
      port_end_station <= 1'b1; // R15
    end
  end

  // Real-time clock inputs through two flip-flops
  logic        rtc_valid_s1_reg;
  logic        rtc_valid_s2_reg;
  logic [63:0] rtc_time_s1_reg;
  logic [63:0] rtc_time_s2_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rtc_valid_s1_reg <= 1'b0;
      rtc_valid_s2_reg <= 1'b0;
      rtc_time_s1_reg  <= '0;
      rtc_time_s2_reg  <= '0;
    end else begin
      rtc_valid_s1_reg <= rtc_valid;
      rtc_valid_s2_reg <= rtc_valid_s1_reg;
      rtc_time_s1_reg  <= rtc_time;
      rtc_time_s2_reg  <= rtc_time_s1_reg;
    end
  end

  // Startup time load
  timebase_pkg::time_state_type tstate_reg;
  timebase_pkg::time_state_type tstate_next;

  always_comb begin
    tstate_next = tstate_reg;
    case (tstate_reg)
      timebase_pkg::ST_WAIT_RTC: begin
        if (rtc_valid_s2_reg) begin
          tstate_next = timebase_pkg::ST_LOAD;
        end
      end
      timebase_pkg::ST_LOAD: tstate_next = timebase_pkg::ST_RUN;
      timebase_pkg::ST_RUN:  tstate_next = timebase_pkg::ST_RUN;
      default:               tstate_next = timebase_pkg::ST_WAIT_RTC;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tstate_reg <= timebase_pkg::ST_WAIT_RTC;
    end else begin
      tstate_reg <= tstate_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sys_time       <= '0;
      sys_time_valid <= 1'b0;
    end else if (tstate_reg == timebase_pkg::ST_LOAD) begin
      sys_time       <= rtc_time_s2_reg; // R16
      sys_time_valid <= 1'b1;
    end else if (tstate_reg == timebase_pkg::ST_RUN) begin
      sys_time       <= sys_time + timebase_pkg::NS_PER_CYCLE; // R16
    end
  end

  // Checks
  logic [15:0] hold_cnt_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_cnt_reg <= '0;
    end else if (tb100k_tick || $changed(tb100k_clk)) begin
      hold_cnt_reg <= '0;
    end else if (hold_cnt_reg != 16'hFFFF) begin
      hold_cnt_reg <= hold_cnt_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  prof_default_a: assert property (!port_explicit[0] |-> port_profile[0] == 1'b0) // R13
    else $error("port without choice not on generalized profile");
  prof_l34_a: assert property (port_profile[0] |-> port_l34_udp[0] && port_delay_rr[0]) // R14
    else $error("2008 profile port not on layer 3-4 transport");
  end_station_a: assert property (##1 port_end_station) // R15
    else $error("port role left end station");
  time_load_a: assert property ((tstate_reg == timebase_pkg::ST_LOAD) |=> // R16
                                sys_time == $past(rtc_time_s2_reg) && sys_time_valid)
    else $error("system time not loaded from rtc");
  time_run_a: assert property ((tstate_reg == timebase_pkg::ST_RUN) |=> // R16
                               sys_time == $past(sys_time) + timebase_pkg::NS_PER_CYCLE)
    else $error("system time not advancing by one period");
  onboard_align_a: assert property (onboard_tick |-> $past(prim_sum) >= 3'd2) // R5
    else $error("onboard tick off primary pair");
  mode_switch_a: assert property ($changed(mode_reg) |-> $past(tb100k_tick)) // R17
    else $error("mode changed away from 100 kHz edge");
  ctr_user_off_a: assert property ((mode_reg == timebase_pkg::MODE_USER) |=> // R17
                                   ctr_src_tick == '0 && !ai_tb_tick)
    else $error("driver timebase active in user mode");
  tb100k_hold_a: assert property ($changed(tb100k_clk) |-> // R18
                                  $past(hold_cnt_reg) >= 16'(timebase_pkg::TB100K_MIN_HOLD))
    else $error("100 kHz half period too short");

  mode_user_c: cover property ($rose(mode_is_user));
  time_loaded_c: cover property ($rose(sys_time_valid));
  port_ptp08_c: cover property ($rose(port_profile[0]));
  carrier_user_c: cover property (mode_is_user && module_master_clk[0]);

endmodule : timebase_clock_tree

// file: include/timebase_pkg.sv
// Purpose: Shared constants and types for the chassis timebase clock tree
// Assumes: Single core clock at 40 MHz; all timebases carried as tick streams
// Notes:   Frequencies in Hz; phase increments are 32-bit fraction per core cycle
package timebase_pkg;

  localparam longint CORE_HZ          = 40_000_000;
  localparam longint OSC_HZ           = 100_000_000;
  localparam longint PRIMARY_HZ       = 80_000_000;
  localparam longint TB20_HZ          = 20_000_000;
  localparam longint TB100K_HZ        = 100_000;
  localparam longint ONBOARD_HZ       = 40_000_000;
  localparam longint CARRIER0_HZ      = 13_107_200;
  localparam longint CARRIER1_HZ      = 12_800_000;
  localparam longint CARRIER2_HZ      = 10_000_000;

  localparam int     FRAC_W           = 32;
  localparam int     TICK_W           = 2;
  localparam int     INC_W            = FRAC_W + TICK_W;
  localparam int     TRIM_W           = 24;
  localparam int     DIV_W            = 9;
  localparam int     NUM_CARRIERS     = 3;

  // Phase increments per core cycle
  localparam logic [INC_W-1:0] PRIMARY_INC =
    INC_W'((PRIMARY_HZ * 64'h0000_0001_0000_0000) / CORE_HZ);
  localparam logic [INC_W-1:0] CARRIER_INC [NUM_CARRIERS] = '{
    INC_W'((CARRIER0_HZ * 64'h0000_0001_0000_0000) / CORE_HZ),
    INC_W'((CARRIER1_HZ * 64'h0000_0001_0000_0000) / CORE_HZ),
    INC_W'((CARRIER2_HZ * 64'h0000_0001_0000_0000) / CORE_HZ)
  };

  // Half periods in primary ticks: divide by 4 and by 800
  localparam logic [DIV_W-1:0] DIV20_HALF   = DIV_W'(PRIMARY_HZ / (2 * TB20_HZ));
  localparam logic [DIV_W-1:0] DIV100K_HALF = DIV_W'(PRIMARY_HZ / (2 * TB100K_HZ));
  localparam int               PRIMARY_PER_ONBOARD = int'(PRIMARY_HZ / ONBOARD_HZ);

  // System time advance per core cycle
  localparam int               CORE_PERIOD_NS = 25;
  localparam logic [63:0]      NS_PER_CYCLE   = 64'(1_000_000_000 / CORE_HZ);
  localparam int               TB100K_MIN_HOLD = 100;

  localparam logic [DIV_W-1:0] DERIVED_HALF_RST = 9'h001;

  typedef enum logic [1:0] {
    MODE_DRIVER = 2'b00,
    MODE_USER   = 2'b01
  } mode_type;

  typedef enum logic [2:0] {
    SRC_TB80    = 3'h0,
    SRC_TB20    = 3'h1,
    SRC_TB100K  = 3'h2,
    SRC_C13     = 3'h3,
    SRC_C12P8   = 3'h4,
    SRC_C10     = 3'h5,
    SRC_OFF     = 3'h6
  } src_type;

  typedef enum logic {
    PROF_GPTP   = 1'b0,
    PROF_PTP08  = 1'b1
  } profile_type;

  typedef enum logic [1:0] {
    ST_WAIT_RTC = 2'b00,
    ST_LOAD     = 2'b01,
    ST_RUN      = 2'b11
  } time_state_type;

endpackage : timebase_pkg
